//--- common/irs_consts.vh
// Purpose: constants for the serial register read slave
// Assumes: 125 MHz system clock
// Notes:   all offsets, codes and counts live here
`ifndef IRS_CONSTS_VH
`define IRS_CONSTS_VH
// fixed upper five address bits
`define IRS_ADDR_UPPER    5'h17
// read-routing selection register sub-address
`define IRS_ROUTE_SUBADDR 8'hFF
`define IRS_ROUTE_RESET   4'h0
// pointer reset value
`define IRS_PTR_RESET     8'h00
// clock period in ns and stretch time in us
`define IRS_CLK_NS        8
`define IRS_STRETCH_US    128
`define IRS_STRETCH_CYC   ((`IRS_STRETCH_US * 1000) / `IRS_CLK_NS)
// registers 00h..8Fh need the wait
`define IRS_SLOW_LAST     8'h8F
`endif

//--- core/irs_regmem.v
// Purpose: small register array read by the serial slave
// Assumes: one write port, one registered read port
// Notes:   contents are loaded by the decoder cores outside this block
`timescale 1ns/1ns
module irs_regmem (
   input  wire       i_clk,
   input  wire       i_we,
   input  wire [7:0] i_waddr,
   input  wire [7:0] i_wdata,
   input  wire [7:0] i_raddr,
   output reg  [7:0] o_rdata
);
   reg [7:0] mem [0:255];

   // write then registered read
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
   end
endmodule

//--- core/irs_slave.v
// Purpose: slave side of the two-phase register read transaction
// Assumes: scl and sda are sampled by I_MCLK, far faster than the bus
// Notes:   write transfers only load the pointer; no data writes here
//
// Summary of operation
// RULE1 - a read is an address phase loading the pointer, then a data phase.
// RULE2 - the master opens the address phase with start, address and bit 0.
// RULE3 - the device acknowledges its address and the sub-address byte.
// RULE4 - the master ends the address phase with stop and sends no data.
// RULE5 - the master opens the data phase with start, address and bit 1.
// RULE6 - the device sends bytes msb first from the loaded pointer.
// RULE7 - the master acknowledges each byte it wants continued.
// RULE8 - on a not-acknowledge the device releases sda until the stop.
// RULE9 - address select pins are caught when reset is released.
// RULE10 - reads go to the lowest core whose routing bit is set.
// RULE11 - the device may hold scl low for wait periods.
// RULE12 - an acknowledged read byte advances the pointer by one.
`timescale 1ns/1ns
`include "irs_consts.vh"
module irs_slave #(
   parameter STRETCH_CYC = `IRS_STRETCH_CYC
) (
   input  wire       I_MCLK,
   input  wire       I_SYS_RST,
   input  wire       i_scl,
   input  wire       i_sda,
   input  wire       i_addr_select_bit0,
   input  wire       i_addr_select_bit1,
   input  wire [3:0] i_route_sel,
   input  wire       i_core_busy,
   input  wire       i_mem_we,
   input  wire [7:0] i_mem_waddr,
   input  wire [7:0] i_mem_wdata,
   output reg        o_sda_oe_n,
   output wire       o_sda_out,
   output reg        o_scl_oe_n,
   output wire       o_scl_out,
   output reg  [1:0] o_core_sel,
   output reg  [7:0] o_reg_ptr,
   output reg        o_busy
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_ADDR  = 3'h1;
   localparam ST_AACK  = 3'h2;
   localparam ST_SUB   = 3'h3;
   localparam ST_SACK  = 3'h4;
   localparam ST_TX    = 3'h5;
   localparam ST_MACK  = 3'h6;
   localparam ST_WAIT  = 3'h7;

   // lowest set routing bit picks the core
   function [1:0] lowest_core;
      input [3:0] bits;
      begin
         if (bits[0]) lowest_core = 2'h0;
         else if (bits[1]) lowest_core = 2'h1;
         else if (bits[2]) lowest_core = 2'h2;
         else lowest_core = 2'h3;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers: two flops before any logic looks
   reg [1:0] scl_sync;
   reg [1:0] sda_sync;
   reg [1:0] as0_sync;
   reg [1:0] as1_sync;
   reg       scl_q;
   reg       sda_q;
   reg       rst_q;
   reg [6:0] my_addr;

   always @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         scl_q    <= 1'b1;
         sda_q    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], i_scl};
         sda_sync <= {sda_sync[0], i_sda};
         scl_q    <= scl_sync[1];
         sda_q    <= sda_sync[1];
      end
      as0_sync <= {as0_sync[0], i_addr_select_bit0};
      as1_sync <= {as1_sync[0], i_addr_select_bit1};
      rst_q    <= I_SYS_RST;
   end

   wire scl_rise = scl_sync[1] & ~scl_q;
   wire scl_fall = ~scl_sync[1] & scl_q;
   wire start_c  = scl_sync[1] & scl_q & sda_q & ~sda_sync[1];
   wire stop_c   = scl_sync[1] & scl_q & ~sda_q & sda_sync[1];

   // RULE9 strap latch
   // caught on the first clock after reset release, never under reset
   always @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         my_addr <= {`IRS_ADDR_UPPER, 2'h0};
      end else if (rst_q) begin
         my_addr <= {`IRS_ADDR_UPPER, as1_sync[1], as0_sync[1]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register array read at the pointer
   wire [7:0] rd_byte;
   irs_regmem u_mem (
      .i_clk   (I_MCLK),
      .i_we    (i_mem_we),
      .i_waddr (i_mem_waddr),
      .i_wdata (i_mem_wdata),
      .i_raddr (o_reg_ptr),
      .o_rdata (rd_byte)
   );

   ////////////////////////////////////////////////////////////////////////
   // transaction state
   reg [2:0]  state;
   reg [3:0]  bit_cnt;
   reg [7:0]  shreg;
   reg        rd_dir;
   reg [16:0] wait_cnt;
   reg        data_set;

   assign o_sda_out = 1'b0;
   assign o_scl_out = 1'b0;

   // main sequencer; open-drain enables are active low
   always @(posedge I_MCLK) begin
      if (I_SYS_RST) begin
         state      <= ST_IDLE;
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         rd_dir     <= 1'b0;
         o_sda_oe_n <= 1'b1;
         o_scl_oe_n <= 1'b1;
         o_reg_ptr  <= `IRS_PTR_RESET;
         o_core_sel <= 2'h0;
         o_busy     <= 1'b0;
         wait_cnt   <= 17'h00000;
         data_set   <= 1'b0;
      end else if (stop_c) begin
         // RULE8 release on stop
         state      <= ST_IDLE;
         data_set   <= 1'b0;
         o_sda_oe_n <= 1'b1;
         o_scl_oe_n <= 1'b1;
         o_busy     <= 1'b0;
      end else if (start_c) begin
         // RULE1 every start begins a fresh phase
         state      <= ST_ADDR;
         bit_cnt    <= 4'h0;
         data_set   <= 1'b0;
         o_sda_oe_n <= 1'b1;
         o_busy     <= 1'b1;
      end else begin
         case (state)
            ST_IDLE: begin
               o_sda_oe_n <= 1'b1;
            end
            ST_ADDR, ST_SUB: begin
               if (scl_rise) begin
                  shreg   <= {shreg[6:0], sda_sync[1]};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == 4'h8) begin
                  bit_cnt <= 4'h0;
                  if (state == ST_ADDR) begin
                     // RULE3 ack own address only
                     if (shreg[7:1] == my_addr) begin
                        rd_dir     <= shreg[0];
                        o_sda_oe_n <= 1'b0;
                        o_core_sel <= lowest_core(i_route_sel); // RULE10
                        state      <= ST_AACK;
                     end else begin
                        state <= ST_IDLE;
                     end
                  end else begin
                     // RULE3 ack sub-address and load pointer
                     o_reg_ptr  <= shreg;
                     o_sda_oe_n <= 1'b0;
                     state      <= ST_SACK;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (rd_dir) begin
                     // RULE6 first byte from loaded pointer
                     shreg      <= {rd_byte[6:0], 1'b0};
                     o_sda_oe_n <= rd_byte[7];
                     state      <= ST_TX;
                  end else begin
                     o_sda_oe_n <= 1'b1;
                     state      <= ST_SUB;
                  end
               end
            end
            ST_SACK: begin
               // RULE4 nothing further expected before stop
               if (scl_fall) begin
                  o_sda_oe_n <= 1'b1;
                  state      <= ST_IDLE;
               end
            end
            ST_TX: begin
               // RULE6 shift out msb first on each falling edge
               if (scl_fall) begin
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h7) begin
                     o_sda_oe_n <= 1'b1;
                     state      <= ST_MACK;
                  end else begin
                     o_sda_oe_n <= shreg[7];
                     shreg      <= {shreg[6:0], 1'b0};
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  if (!sda_sync[1]) begin
                     // RULE12 advance pointer on master ack
                     // RULE7 master wants another byte
                     o_reg_ptr <= o_reg_ptr + 8'h01;
                     wait_cnt  <= (o_reg_ptr <= `IRS_SLOW_LAST) ?
                                  STRETCH_CYC[16:0] : 17'h00000;
                     state     <= ST_WAIT;
                  end else begin
                     // RULE8 not-ack releases sda
                     o_sda_oe_n <= 1'b1;
                     state      <= ST_IDLE;
                  end
               end
            end
            ST_WAIT: begin
               // RULE11 hold scl low while the core fetches the byte
               if (scl_fall) begin
                  o_scl_oe_n <= 1'b0;
               end
               if (data_set) begin
                  // sda settled a cycle ago, so scl may rise now
                  data_set   <= 1'b0;
                  o_scl_oe_n <= 1'b1;
                  state      <= ST_TX;
               end else if (!o_scl_oe_n || !scl_sync[1]) begin
                  if (wait_cnt != 17'h00000) begin
                     wait_cnt <= wait_cnt - 17'h00001;
                  end
                  // bit7 goes out before scl is let go; moving sda
                  // with scl rising would break the data setup time
                  if ((wait_cnt == 17'h00000) && !i_core_busy
                      && !o_scl_oe_n) begin
                     data_set   <= 1'b1;
                     bit_cnt    <= 4'h0;
                     shreg      <= {rd_byte[6:0], 1'b0};
                     o_sda_oe_n <= rd_byte[7];
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

//--- tb/irs_slave_props.sv
// Purpose: port checks for the serial register read slave
// Assumes: i_scl and i_sda are the resolved wire levels
// Notes:   stall cycles are left out of the stretch count
`timescale 1ns/1ns
module irs_slave_props #(
   parameter STRETCH_CYC = 20
) (
   input wire       I_MCLK,
   input wire       I_SYS_RST,
   input wire       i_scl,
   input wire       i_sda,
   input wire       i_core_busy,
   input wire       o_sda_oe_n,
   input wire       o_scl_oe_n,
   input wire [7:0] o_reg_ptr,
   input wire       o_busy
);
   integer cnt = 0;
   // one bound then covers both the fixed and the stall-driven stretch
   always @(posedge I_MCLK) begin
      cnt <= (I_SYS_RST || o_scl_oe_n) ? 0 : cnt + !i_core_busy;
   end
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   a_rst_state: assert property (disable iff (1'b0)
      I_SYS_RST |=> o_sda_oe_n && o_scl_oe_n && !o_busy && o_reg_ptr == 8'h00)
      else $error("outputs not cleared by reset");
   a_start_busy: assert property (
      $fell(i_sda) && i_scl && $past(i_scl) |-> ##[1:6] o_busy)
      else $error("start not taken");
   a_stop_free: assert property (
      $rose(i_sda) && i_scl && $past(i_scl) |-> ##[1:6] (!o_busy && o_sda_oe_n))
      else $error("stop did not free the bus");
   a_idle_quiet: assert property (
      !o_busy && !$past(o_busy) |-> o_sda_oe_n && o_scl_oe_n)
      else $error("line held while idle");
   a_sda_grab: assert property (
      $fell(o_sda_oe_n) |-> !i_scl && o_busy)
      else $error("sda pulled while scl high");
   a_sda_steady: assert property (
      i_scl && $past(i_scl, 3) && o_busy |-> $stable(o_sda_oe_n))
      else $error("sda moved while scl high");
   a_scl_grab: assert property (
      $fell(o_scl_oe_n) |-> !i_scl)
      else $error("scl pulled while high");
   a_stretch_max: assert property (
      cnt <= STRETCH_CYC + 3)
      else $error("stretch too long");
endmodule
bind irs_slave irs_slave_props #(.STRETCH_CYC(STRETCH_CYC)) i_props (.I_MCLK,
   .I_SYS_RST, .i_scl, .i_sda, .i_core_busy, .o_sda_oe_n, .o_scl_oe_n,
   .o_reg_ptr, .o_busy);

//--- tb/irs_mst.sv
// Purpose: bus master model on open-drain scl and sda
// Assumes: pull-ups on both wires, 80 ns bit period
// Notes:   waits while the slave holds scl low, up to 400 cycles
`timescale 1ns/1ns
module irs_mst (
   input  wire i_clk,
   input  wire i_scl,
   input  wire i_sda,
   output reg  o_scl_lo = 1'b0,
   output reg  o_sda_lo = 1'b0
);
   integer m, j;
   task start;
      @(posedge i_clk) o_sda_lo <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_scl_lo <= 1'b1;
   endtask
   task stop;
      @(posedge i_clk) o_sda_lo <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_scl_lo <= 1'b0;
      repeat (5) @(posedge i_clk);
      o_sda_lo <= 1'b0;
      repeat (5) @(posedge i_clk);
   endtask
   // long low half leaves room for the slave's sync delay
   task bitx(input b, output r);
      @(posedge i_clk) o_sda_lo <= !b;
      repeat (5) @(posedge i_clk);
      o_scl_lo <= 1'b0;
      for (m = 0; !i_scl && m < 400; m = m + 1) @(posedge i_clk);
      repeat (3) @(posedge i_clk);
      r = i_sda;
      o_scl_lo <= 1'b1;
   endtask
   task xfer(input [7:0] d, input a, output [7:0] q, output k);
      for (j = 0; j < 8; j = j + 1) bitx(d[7-j], q[7-j]);
      bitx(a, k);
   endtask
endmodule

//--- tb/tb_top.sv
// Purpose: random and corner register reads through the slave
// Assumes: stretch count cut to 20 cycles
// Notes:   expected bytes come from a mirror of the loaded array
`timescale 1ns/1ns
`include "irs_consts.vh"
module tb_top;
   reg        clk = 1'b0;
   reg        rst = 1'b1;
   reg  [1:0] sel = 2'h0;
   reg  [3:0] rs = 4'h1;
   reg        cb = 1'b0;
   reg        we = 1'b0;
   reg  [7:0] wa = 8'h00;
   reg  [7:0] wd = 8'h00;
   reg  [7:0] mem [0:255];
   wire       ml, md, soe, coe, bz, sdo, sco;
   wire [1:0] cs;
   wire [7:0] ptr;
   wire       scl = !ml && coe;
   wire       sda = !md && soe;
   integer    n_mismatch = 0;
   integer    check_count = 0;
   integer    t = 0;
   integer    hold = 0;
   integer    i;
   always #4 clk = !clk;
   irs_slave #(.STRETCH_CYC(20)) i_irs_slave (.I_MCLK(clk), .I_SYS_RST(rst),
      .i_scl(scl), .i_sda(sda), .i_addr_select_bit0(sel[0]),
      .i_addr_select_bit1(sel[1]), .i_route_sel(rs), .i_core_busy(cb),
      .i_mem_we(we), .i_mem_waddr(wa), .i_mem_wdata(wd), .o_sda_oe_n(soe),
      .o_sda_out(sdo), .o_scl_oe_n(coe), .o_scl_out(sco), .o_core_sel(cs),
      .o_reg_ptr(ptr), .o_busy(bz));
   irs_mst i_irs_mst (.i_clk(clk), .i_scl(scl), .i_sda(sda), .o_scl_lo(ml),
      .o_sda_lo(md));
   // random core stalls, scl hold count, plus the hang limit
   always @(posedge clk) begin
      cb <= ($urandom % 4) == 0;
      t = t + 1;
      if (!coe) hold = hold + 1;
      if (t == 80000) begin
         n_mismatch = n_mismatch + 1;
         final_report;
      end
   end
   task chk(input [7:0] g, input [7:0] e);
      check_count = check_count + 1;
      if (g !== e) begin
         n_mismatch = n_mismatch + 1;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task final_report;
      if (n_mismatch == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   function [7:0] low_core(input [3:0] r);
      low_core = r[0] ? 8'h00 : r[1] ? 8'h01 : r[2] ? 8'h02 : 8'h03;
   endfunction
   // straps are set with reset high and held well past its release
   task do_rst(input [1:0] s);
      @(posedge clk) rst <= 1'b1;
      sel <= s;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   task rd(input [7:0] p, input integer nb, input [3:0] r);
      reg [7:0] q;
      reg       k;
      integer   n;
      @(posedge clk) rs <= r;
      i_irs_mst.start;
      i_irs_mst.xfer({`IRS_ADDR_UPPER, sel, 1'b0}, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      i_irs_mst.xfer(p, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      i_irs_mst.stop;
      i_irs_mst.start;
      i_irs_mst.xfer({`IRS_ADDR_UPPER, sel, 1'b1}, 1'b1, q, k);
      chk({7'h00, k}, 8'h00);
      chk({6'h00, cs}, low_core(r));
      for (n = 0; n < nb; n = n + 1) begin
         i_irs_mst.xfer(8'hFF, n == nb - 1, q, k);
         chk(q, mem[p + n[7:0]]);
      end
      chk({7'h00, soe}, 8'h01);
      i_irs_mst.stop;
      chk(ptr, p + nb[7:0] - 8'h01);
      chk({6'h00, sdo, bz}, 8'h00);
      chk({7'h00, sco}, 8'h00);
   endtask
   task refuse;
      reg [7:0] q;
      reg       k;
      i_irs_mst.start;
      i_irs_mst.xfer({`IRS_ADDR_UPPER, ~sel, 1'b0}, 1'b1, q, k);
      chk({7'h00, k}, 8'h01);
      i_irs_mst.stop;
      i_irs_mst.start;
      i_irs_mst.xfer({`IRS_ADDR_UPPER, sel, 1'b0}, 1'b1, q, k);
      i_irs_mst.xfer(8'h10, 1'b1, q, k);
      i_irs_mst.xfer(8'h5A, 1'b1, q, k);
      chk({7'h00, k}, 8'h01);
      i_irs_mst.stop;
   endtask
   initial begin
      i = $urandom(32'h135B0DFF);
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      // fill the array and keep a mirror for expectations
      for (i = 0; i < 256; i = i + 1) begin
         @(posedge clk);
         mem[i] = $urandom;
         we <= 1'b1;
         wa <= i[7:0];
         wd <= mem[i];
      end
      @(posedge clk) we <= 1'b0;
      rd(8'h8E, 4, 4'h6);
      // two acks at 8Eh and 8Fh each hold scl for at least 21 cycles
      chk({7'h00, hold >= 40}, 8'h01);
      rd(8'hFE, 3, 4'h8);
      refuse;
      for (i = 0; i < 4; i = i + 1) begin
         do_rst(i[1:0]);
         rd($urandom, 1 + $urandom % 4, 1 + $urandom % 15);
      end
      final_report;
   end
endmodule
